// [dps_pkg.sv]
// package of constants and types for the deposition process sequencer
package dps_pkg;
   localparam int unsigned DPS_LAYER_W = 4;
   localparam int unsigned DPS_THK_W = 24;
   localparam int unsigned DPS_PWR_W = 16;
   localparam int unsigned DPS_TIME_W = 32;
   localparam int unsigned DPS_PROC_W = 4;
   localparam logic [DPS_LAYER_W-1:0] DPS_FIRST_LAYER = 4'h0;
   localparam logic [DPS_THK_W-1:0] DPS_THK_RST = 24'h000000;
   localparam logic [DPS_PWR_W-1:0] DPS_PWR_RST = 16'h0000;
   localparam logic [DPS_PROC_W-1:0] DPS_PROC_RST = 4'h0;
   localparam logic [DPS_TIME_W-1:0] DPS_TIME_RST = 32'h00000000;
   localparam logic [DPS_THK_W-1:0] DPS_SIM_RATE = 24'h000001;
   typedef enum logic [2:0] {
      DPS_STOPPED,
      DPS_PRECOND,
      DPS_DEPOSIT,
      DPS_FEED,
      DPS_IDLE,
      DPS_WAIT_START,
      DPS_LAYER_STOP
   } dps_phase_t;
endpackage : dps_pkg

// [dps_cmd_if.sv]
// interface carrying decoded operator commands to the sequencer core
interface dps_cmd_if;
   import dps_pkg::*;
   logic start;
   logic start_layer;
   logic stop_layer;
   logic restart_layer;
   logic next_layer;
   logic abort;
   logic zero;
   logic mode_toggle;
   modport src (output start, start_layer, stop_layer, restart_layer, next_layer, abort, zero,
                mode_toggle);
   modport dst (input start, start_layer, stop_layer, restart_layer, next_layer, abort, zero,
                mode_toggle);
endinterface : dps_cmd_if

// [dps_cmd_merge.sv]
// merges operator command sources into command strobes; only the toggle key is reduced to a single-cycle pulse
module dps_cmd_merge (
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic start_i,
   input wire logic panel_layer_start_i,
   input wire logic serial_layer_start_i,
   input wire logic dig_layer_start_i,
   input wire logic stop_layer_i,
   input wire logic restart_layer_i,
   input wire logic next_layer_i,
   input wire logic abort_i,
   input wire logic zero_i,
   input wire logic mode_toggle_i,
   dps_cmd_if.src cmd
);
   // ---------------------------------------------------------------
   // command pulses
   // ---------------------------------------------------------------
   logic tog_prev_q;
   // toggle key is edge detected so one press is one switch
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         tog_prev_q <= 1'b0;
      end else begin
         tog_prev_q <= mode_toggle_i;
      end
   end
   assign cmd.start = start_i;
   assign cmd.start_layer = panel_layer_start_i | serial_layer_start_i | dig_layer_start_i;
   assign cmd.stop_layer = stop_layer_i;
   assign cmd.restart_layer = restart_layer_i;
   assign cmd.next_layer = next_layer_i;
   assign cmd.abort = abort_i;
   assign cmd.zero = zero_i;
   assign cmd.mode_toggle = mode_toggle_i & ~tog_prev_q;
endmodule : dps_cmd_merge

// [dps_sequencer.sv]
// deposition process sequencer: layer phase control and output selection
module dps_sequencer
   import dps_pkg::*;
(
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic start_i,
   input wire logic panel_layer_start_i,
   input wire logic serial_layer_start_i,
   input wire logic dig_layer_start_i,
   input wire logic stop_layer_i,
   input wire logic restart_layer_i,
   input wire logic next_layer_i,
   input wire logic abort_i,
   input wire logic zero_i,
   input wire logic mode_toggle_i,
   input wire logic proc_sel_req_i,
   input wire logic [DPS_PROC_W-1:0] proc_sel_i,
   input wire logic [DPS_LAYER_W-1:0] layer_count_i,
   input wire logic layer_manual_start_i,
   input wire logic next_manual_start_i,
   input wire logic feed_en_i,
   input wire logic idle_en_i,
   input wire logic precond_done_i,
   input wire logic feed_done_i,
   input wire logic idle_done_i,
   input wire logic [DPS_THK_W-1:0] final_thk_i,
   input wire logic [DPS_THK_W-1:0] thk_limit_i,
   input wire logic [DPS_TIME_W-1:0] time_setpoint_i,
   input wire logic [DPS_THK_W-1:0] sensor_thk_inc_i,
   input wire logic simulate_i,
   input wire logic [DPS_PWR_W-1:0] pid_power_i,
   input wire logic [DPS_PWR_W-1:0] knob_power_i,
   output logic [2:0] phase_o,
   output logic [DPS_LAYER_W-1:0] layer_o,
   output logic [DPS_PROC_W-1:0] proc_o,
   output logic proc_sel_refused_o,
   output logic manual_o,
   output logic pid_en_o,
   output logic [DPS_PWR_W-1:0] power_o,
   output logic [DPS_THK_W-1:0] thickness_o,
   output logic relay_o,
   output logic running_o
);
   // ---------------------------------------------------------------
   // command merge
   // ---------------------------------------------------------------
   dps_cmd_if cmd ();
   dps_cmd_merge u_merge (
      .mclk_i(mclk_i),
      .srst_i(srst_i),
      .start_i(start_i),
      .panel_layer_start_i(panel_layer_start_i),
      .serial_layer_start_i(serial_layer_start_i),
      .dig_layer_start_i(dig_layer_start_i),
      .stop_layer_i(stop_layer_i),
      .restart_layer_i(restart_layer_i),
      .next_layer_i(next_layer_i),
      .abort_i(abort_i),
      .zero_i(zero_i),
      .mode_toggle_i(mode_toggle_i),
      .cmd(cmd)
   );

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // phases in which the process counts as running
   function automatic logic dps_is_run(input dps_phase_t p);
      dps_is_run = (p == DPS_PRECOND) || (p == DPS_DEPOSIT) || (p == DPS_FEED) ||
                   (p == DPS_IDLE);
   endfunction : dps_is_run

   // true when the given layer index is the last one programmed
   // a layer count of zero is taken as a single layer, never as none
   function automatic logic dps_is_last(input logic [DPS_LAYER_W-1:0] l,
                                        input logic [DPS_LAYER_W-1:0] n);
      dps_is_last = (n == DPS_FIRST_LAYER) || (l >= n - 4'h1);
   endfunction : dps_is_last

   dps_phase_t phase_q;
   dps_phase_t phase_d;
   logic [DPS_LAYER_W-1:0] layer_q;
   logic [DPS_LAYER_W-1:0] layer_d;
   logic manual_q;
   logic layer_begin;
   logic layer_done;
   logic [DPS_THK_W-1:0] thk_q;
   logic [DPS_THK_W-1:0] thk_inc;
   logic [DPS_TIME_W-1:0] layer_time_q;
   logic thk_reached;

   // simulate swaps the sensor increment for a fixed generated rate
   assign thk_inc = simulate_i ? DPS_SIM_RATE : sensor_thk_inc_i;
   assign thk_reached = (thk_q >= final_thk_i);

   // ---------------------------------------------------------------
   // next-phase logic
   // ---------------------------------------------------------------
   // abort overrides every other command for phase and layer; a toggle in the same cycle still flips manual_q
   always_comb begin
      phase_d = phase_q;
      layer_d = layer_q;
      layer_begin = 1'b0;
      layer_done = 1'b0;
      if (cmd.abort) begin
         phase_d = DPS_STOPPED;
         layer_d = DPS_FIRST_LAYER;
      end else if (cmd.mode_toggle && !manual_q) begin
         // manual entry jumps to deposition from any phase: stopped, waiting, running or suspended
         if (phase_q != DPS_DEPOSIT) begin
            layer_begin = (phase_q == DPS_STOPPED) || (phase_q == DPS_WAIT_START);
         end
         phase_d = DPS_DEPOSIT;
      end else begin
         case (phase_q)
            DPS_STOPPED: begin
               if (cmd.start) begin
                  layer_d = DPS_FIRST_LAYER;
                  if (layer_manual_start_i) begin
                     phase_d = DPS_WAIT_START;
                  end else begin
                     phase_d = DPS_PRECOND;
                     layer_begin = 1'b1;
                  end
               end
            end
            DPS_WAIT_START: begin
               if (cmd.start_layer) begin
                  phase_d = DPS_PRECOND;
                  layer_begin = 1'b1;
               end
            end
            DPS_PRECOND: begin
               if (cmd.stop_layer) begin
                  phase_d = DPS_LAYER_STOP;
               end else if (precond_done_i) begin
                  phase_d = DPS_DEPOSIT;
               end
            end
            DPS_DEPOSIT: begin
               if (cmd.stop_layer) begin
                  phase_d = DPS_LAYER_STOP;
               end else if (thk_reached && !manual_q) begin
                  // manual mode leaves the end of deposition to the operator
                  if (feed_en_i) begin
                     phase_d = DPS_FEED;
                  end else if (idle_en_i) begin
                     phase_d = DPS_IDLE;
                  end else begin
                     layer_done = 1'b1;
                  end
               end
            end
            DPS_FEED: begin
               if (cmd.stop_layer) begin
                  phase_d = DPS_LAYER_STOP;
               end else if (feed_done_i) begin
                  if (idle_en_i) begin
                     phase_d = DPS_IDLE;
                  end else begin
                     layer_done = 1'b1;
                  end
               end
            end
            DPS_IDLE: begin
               if (cmd.stop_layer) begin
                  phase_d = DPS_LAYER_STOP;
               end else if (idle_done_i) begin
                  layer_done = 1'b1;
               end
            end
            DPS_LAYER_STOP: begin
               // only the two continuations leave this phase, besides abort and manual entry
               if (cmd.restart_layer) begin
                  phase_d = DPS_PRECOND;
                  layer_begin = 1'b1;
               end else if (cmd.next_layer) begin
                  if (dps_is_last(layer_q, layer_count_i)) begin
                     phase_d = DPS_STOPPED;
                     layer_d = DPS_FIRST_LAYER;
                  end else begin
                     layer_d = layer_q + 4'h1;
                     phase_d = DPS_PRECOND;
                     layer_begin = 1'b1;
                  end
               end
            end
            default: begin
               phase_d = DPS_STOPPED;
            end
         endcase
         // completion hands over to the next layer or halts
         if (layer_done) begin
            if (dps_is_last(layer_q, layer_count_i)) begin
               phase_d = DPS_STOPPED;
               layer_d = DPS_FIRST_LAYER;
            end else if (next_manual_start_i) begin
               layer_d = layer_q + 4'h1;
               phase_d = DPS_WAIT_START;
            end else begin
               layer_d = layer_q + 4'h1;
               phase_d = DPS_PRECOND;
               layer_begin = 1'b1;
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // state registers
   // ---------------------------------------------------------------
   // phase and layer index
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         phase_q <= DPS_STOPPED;
         layer_q <= DPS_FIRST_LAYER;
      end else begin
         phase_q <= phase_d;
         layer_q <= layer_d;
      end
   end

   // auto or manual output control
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         manual_q <= 1'b0;
      end else if (cmd.mode_toggle) begin
         manual_q <= ~manual_q;
      end
   end

   // current process, changed only while stopped
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         proc_o <= DPS_PROC_RST;
         proc_sel_refused_o <= 1'b0;
      end else begin
         proc_sel_refused_o <= proc_sel_req_i && (phase_q != DPS_STOPPED);
         if (proc_sel_req_i && phase_q == DPS_STOPPED) begin
            proc_o <= proc_sel_i;
         end
      end
   end

   // ---------------------------------------------------------------
   // thickness and layer timer
   // ---------------------------------------------------------------
   // accumulation saturates so a runaway layer never wraps to zero
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         thk_q <= DPS_THK_RST;
      end else if (layer_begin || cmd.zero) begin
         thk_q <= DPS_THK_RST;
      end else if (phase_q == DPS_DEPOSIT) begin
         if (thk_q > ~thk_inc) begin
            thk_q <= {DPS_THK_W{1'b1}};
         end else begin
            thk_q <= thk_q + thk_inc;
         end
      end
   end

   // elapsed cycles of the current layer
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         layer_time_q <= DPS_TIME_RST;
      end else if (layer_begin) begin
         layer_time_q <= DPS_TIME_RST;
      end else if (dps_is_run(phase_q) && layer_time_q != {DPS_TIME_W{1'b1}}) begin
         layer_time_q <= layer_time_q + 32'h00000001;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // power selection; the auto path takes regulator output directly
   // stopped in auto leaves the regulator idle and the output at zero
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         power_o <= DPS_PWR_RST;
         pid_en_o <= 1'b0;
      end else if (manual_q) begin
         power_o <= knob_power_i;
         pid_en_o <= 1'b0;
      end else begin
         power_o <= dps_is_run(phase_q) ? pid_power_i : DPS_PWR_RST;
         pid_en_o <= dps_is_run(phase_q);
      end
   end

   // relay when time setpoint or thickness limit reached within a layer
   // it holds outside a run, so a suspended layer keeps showing its state
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         relay_o <= 1'b0;
      end else if (layer_begin) begin
         relay_o <= 1'b0;
      end else if (dps_is_run(phase_q)) begin
         relay_o <= (layer_time_q >= time_setpoint_i) || (thk_q >= thk_limit_i);
      end
   end

   // status mirrors
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         phase_o <= 3'h0;
         layer_o <= DPS_FIRST_LAYER;
         manual_o <= 1'b0;
         thickness_o <= DPS_THK_RST;
         running_o <= 1'b0;
      end else begin
         phase_o <= phase_q;
         layer_o <= layer_q;
         manual_o <= manual_q;
         thickness_o <= thk_q;
         running_o <= dps_is_run(phase_q);
      end
   end
endmodule : dps_sequencer

// [dps_seq_props.sv]
// assertion checker for the deposition process sequencer
module dps_seq_props
   import dps_pkg::*;
(
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic start_i,
   input wire logic stop_layer_i,
   input wire logic restart_layer_i,
   input wire logic abort_i,
   input wire logic zero_i,
   input wire logic mode_toggle_i,
   input wire logic proc_sel_req_i,
   input wire logic layer_manual_start_i,
   input wire logic precond_done_i,
   input wire logic [DPS_PWR_W-1:0] pid_power_i,
   input wire logic [DPS_PWR_W-1:0] knob_power_i,
   input wire logic [2:0] phase_o,
   input wire logic [DPS_LAYER_W-1:0] layer_o,
   input wire logic proc_sel_refused_o,
   input wire logic manual_o,
   input wire logic pid_en_o,
   input wire logic [DPS_PWR_W-1:0] power_o,
   input wire logic [DPS_THK_W-1:0] thickness_o,
   input wire logic running_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (srst_i);
   // phase_o lags the internal state by one cycle, so the state seen at a command
   // edge is the phase_o sampled one edge later
   logic calm;
   assign calm = !abort_i && !mode_toggle_i && !stop_layer_i;
   property p_refuse;
      proc_sel_req_i && !abort_i ##1 phase_o != 3'h0 |-> ##[0:1] proc_sel_refused_o;
   endproperty
   a_refuse: assert property (p_refuse) else $error("selection not refused");
   property p_zero;
      zero_i |-> ##2 thickness_o == 24'h000000;
   endproperty
   a_zero: assert property (p_zero) else $error("thickness not cleared");
   property p_toggle;
      $rose(mode_toggle_i) && !abort_i |-> ##2 manual_o != $past(manual_o, 2);
   endproperty
   a_toggle: assert property (p_toggle) else $error("control mode not flipped");
   property p_manual;
      $rose(mode_toggle_i) && !abort_i && !manual_o |-> ##[1:3] phase_o == 3'h2 && manual_o;
   endproperty
   a_manual: assert property (p_manual) else $error("manual did not deposit");
   property p_knob;
      (manual_o && $stable(knob_power_i)) [*3] |-> !pid_en_o && power_o == knob_power_i;
   endproperty
   a_knob: assert property (p_knob) else $error("power not from knob");
   property p_pid;
      $fell(manual_o) && running_o |-> ##[0:1] pid_en_o && power_o == pid_power_i;
   endproperty
   a_pid: assert property (p_pid) else $error("power not from regulator");
   property p_start;
      start_i && calm && !layer_manual_start_i && !manual_o ##1 phase_o == 3'h0
         |-> ##1 phase_o == 3'h1 && layer_o == 4'h0;
   endproperty
   a_start: assert property (p_start) else $error("start not in first precondition");
   property p_prec;
      precond_done_i && calm ##1 phase_o == 3'h1 |-> ##1 phase_o == 3'h2;
   endproperty
   a_prec: assert property (p_prec) else $error("no deposition after precondition");
   property p_stop;
      stop_layer_i && !abort_i && !mode_toggle_i ##1 phase_o inside {[3'h1:3'h4]}
         |-> ##1 phase_o == 3'h6;
   endproperty
   a_stop: assert property (p_stop) else $error("layer not suspended");
   property p_rest;
      restart_layer_i && calm ##1 phase_o == 3'h6 |-> ##1 phase_o == 3'h1 && $stable(layer_o);
   endproperty
   a_rest: assert property (p_rest) else $error("layer not repeated");
   property p_abort;
      abort_i |-> ##2 phase_o == 3'h0 && !running_o;
   endproperty
   a_abort: assert property (p_abort) else $error("abort did not stop");
endmodule : dps_seq_props
bind dps_sequencer dps_seq_props u_props (.*);

// [dps_seq_partner.sv]
// far-side model: phase completion reports after a programmable delay
module dps_seq_partner
   import dps_pkg::*;
(
   input wire logic mclk_i,
   input wire logic [2:0] phase_i,
   input wire logic [7:0] dly_i,
   output logic precond_done_o = 1'b0,
   output logic feed_done_o = 1'b0,
   output logic idle_done_o = 1'b0
);
   logic [2:0] ph_q = 3'h0;
   logic [7:0] cnt_q = 8'h0;
   // done is held as a level once due until the 8-bit count wraps; a long dly_i models a slow source
   always @(negedge mclk_i) begin
      cnt_q <= (phase_i == ph_q) ? cnt_q + 8'h1 : 8'h0;
      ph_q <= phase_i;
      // the count only means something once the phase has been seen before
      precond_done_o <= phase_i == 3'h1 && ph_q == phase_i && cnt_q >= dly_i;
      feed_done_o <= phase_i == 3'h3 && ph_q == phase_i && cnt_q >= dly_i;
      idle_done_o <= phase_i == 3'h4 && ph_q == phase_i && cnt_q >= dly_i;
   end
endmodule : dps_seq_partner

// [tb_dps_sequencer.sv]
// self-checking bench for the deposition process sequencer
module tb_dps_sequencer
   import dps_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [10:0] cmd = '0;
   logic [DPS_PROC_W-1:0] sel = '0;
   logic lman = 1'b0, nman = 1'b0, sim = 1'b0;
   logic [DPS_THK_W-1:0] fthk = 24'h000040, inc = 24'h000010;
   logic [DPS_PWR_W-1:0] pid = 16'h0000, knob = 16'h0000;
   logic [7:0] dly = 8'h02;
   logic fen = 1'b1;
   logic [DPS_TIME_W-1:0] tsp = 32'hffffffff;
   int feed_seen = 0;
   logic pd, fd, idn, refused, manual, pid_en, relay, running;
   logic [2:0] phase;
   logic [DPS_LAYER_W-1:0] layer;
   logic [DPS_PROC_W-1:0] proc;
   logic [DPS_PWR_W-1:0] power;
   logic [DPS_THK_W-1:0] thk;
   int errors = 0, num_checks = 0, seed = 34, i;
   always #2 mclk_i = ~mclk_i;
   // cmd bits: start, three layer starts, stop, restart, next, abort, zero, toggle, select
   dps_sequencer u_dut (.mclk_i(mclk_i), .srst_i(srst_i), .start_i(cmd[0]),
      .panel_layer_start_i(cmd[1]), .serial_layer_start_i(cmd[2]), .dig_layer_start_i(cmd[3]),
      .stop_layer_i(cmd[4]), .restart_layer_i(cmd[5]), .next_layer_i(cmd[6]), .abort_i(cmd[7]),
      .zero_i(cmd[8]), .mode_toggle_i(cmd[9]), .proc_sel_req_i(cmd[10]), .proc_sel_i(sel),
      .layer_count_i(4'h3), .layer_manual_start_i(lman), .next_manual_start_i(nman),
      .feed_en_i(fen), .idle_en_i(1'b1), .precond_done_i(pd), .feed_done_i(fd),
      .idle_done_i(idn), .final_thk_i(fthk), .thk_limit_i(24'h000020),
      .time_setpoint_i(tsp), .sensor_thk_inc_i(inc), .simulate_i(sim),
      .pid_power_i(pid), .knob_power_i(knob), .phase_o(phase), .layer_o(layer), .proc_o(proc),
      .proc_sel_refused_o(refused), .manual_o(manual), .pid_en_o(pid_en), .power_o(power),
      .thickness_o(thk), .relay_o(relay), .running_o(running));
   dps_seq_partner u_far (.mclk_i(mclk_i), .phase_i(phase), .dly_i(dly),
      .precond_done_o(pd), .feed_done_o(fd), .idle_done_o(idn));
   // counts cycles shown in feed, so a skipped feed phase can be proven
   always @(negedge mclk_i) begin
      if (phase == 3'h3) begin
         feed_seen++;
      end
   end
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   // one-cycle command pulse, raised and dropped on falling edges
   task automatic pulse(input int b);
      @(negedge mclk_i) cmd[b] = 1'b1;
      @(negedge mclk_i) cmd = '0;
   endtask : pulse
   task automatic idle(input int n);
      repeat (n) @(negedge mclk_i);
   endtask : idle
   // bounded wait; a hang ends the run instead of stalling it
   task automatic wait_ph(input logic [2:0] p);
      int n;
      for (n = 0; n < 600 && phase !== p; n++) @(negedge mclk_i);
      if (phase !== p) begin
         chk("phase timeout", phase, p);
         end_sim();
      end
   endtask : wait_ph
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      knob = $random(seed);
      pid = $random(seed);
      inc = 24'(($random(seed) & 15) + 4);
      idle(3);
      srst_i = 1'b0;
      chk("phase", phase, 3'h0);
      chk("thk", thk, 24'h0);
      sel = $random(seed);
      pulse(10);
      chk("refused", refused, 1'b0);
      idle(3);
      chk("proc", proc, sel);
      // three auto-start layers, with a suspend and repeat in the middle one
      pulse(0);
      for (i = 0; i < 3; i++) begin
         dly = 8'($random(seed) & 7) + 8'h1;
         wait_ph(3'h1);
         chk("layer", layer, i);
         chk("thk", thk, 24'h0);
         chk("relay", relay, 1'b0);
         if (i == 1) begin
            pulse(4);
            wait_ph(3'h6);
            sel = ~sel;
            pulse(10);
            chk("refused", refused, 1'b1);
            idle(3);
            chk("proc", proc, 4'(~sel));
            pulse(5);
            wait_ph(3'h1);
            chk("layer", layer, 4'h1);
         end
         wait_ph(3'h2);
         wait_ph(3'h3);
         chk("thk end", thk >= fthk, 1'b1);
         chk("relay", relay, 1'b1);
         wait_ph(3'h4);
      end
      wait_ph(3'h0);
      chk("running", running, 1'b0);
      // manual first layer released by each source, then skipped and aborted
      lman = 1'b1;
      for (i = 1; i < 4; i++) begin
         pulse(0);
         wait_ph(3'h5);
         chk("layer", layer, 4'h0);
         idle(4);
         chk("hold", phase, 3'h5);
         pulse(i);
         wait_ph(3'h1);
         pulse(4);
         wait_ph(3'h6);
         pulse(6);
         wait_ph(3'h1);
         chk("layer", layer, 4'h1);
         pulse(7);
         wait_ph(3'h0);
      end
      // simulated rate, manual next layer halts, then manual output control
      lman = 1'b0;
      nman = 1'b1;
      sim = 1'b1;
      fen = 1'b0;
      tsp = 32'h00000008;
      i = feed_seen;
      pulse(0);
      wait_ph(3'h2);
      pulse(8);
      idle(1);
      chk("thk zero", thk, 24'h0);
      idle(1);
      chk("thk sim", thk, 24'h1);
      wait_ph(3'h4);
      wait_ph(3'h5);
      chk("layer", layer, 4'h1);
      chk("feed skipped", feed_seen, i);
      pulse(9);
      wait_ph(3'h2);
      idle(4);
      chk("manual", manual, 1'b1);
      chk("pid_en", pid_en, 1'b0);
      chk("power", power, knob);
      chk("relay", relay, 1'b0);
      knob = $random(seed);
      idle(3);
      chk("power", power, knob);
      pulse(9);
      idle(4);
      chk("manual", manual, 1'b0);
      chk("pid_en", pid_en, 1'b1);
      chk("power", power, pid);
      chk("relay time", relay, 1'b1);
      pulse(7);
      wait_ph(3'h0);
      end_sim();
   end
endmodule : tb_dps_sequencer
